/* File: hdl/hba_bus_if.sv */
/*
  Shared host bus wires between the processor end and the hub end.
  Assumes both ends run on their own core clocks; pins are active low except the reset pin, which is high in reset.
  Two-way pins are resolved here from each end's drive and enable.
*/
`timescale 1ns/1ps
`include "hba_regs.svh"
interface hba_bus_if;
  // Bus clock made by the hub end
  logic                     bclk;
  // Processor drive of shared pins
  logic [`HBA_ADDR_W-1:0]   cpu_addr_n_o;
  logic [`HBA_REQ_W-1:0]    cpu_req_n_o;
  logic [1:0]               cpu_strobe_n_o;
  logic                     cpu_avs_n_o;
  logic                     cpu_oe;
  logic                     cpu_bnr_n_o;
  logic                     cpu_bnr_oe;
  // Hub drive of shared pins
  logic                     hub_bnr_n_o;
  logic                     hub_bnr_oe;
  logic [`HBA_ADDR_W-1:0]   hub_strap_n_o;
  logic                     hub_strap_oe;
  // One-way pins
  logic                     symmetric_bus_request_n;
  logic                     priority_agent_request_n;
  logic                     addr_bit20_mask_n;
  logic                     target_ready_n;
  logic [`HBA_BPM_W-1:0]    breakpoint_monitor_pins_n;
  logic                     rst_pin;
  // Resolved wire levels, pulled high when nobody drives
  logic [`HBA_ADDR_W-1:0]   address_n;
  logic [`HBA_REQ_W-1:0]    request_n;
  logic [1:0]               address_source_strobes_n;
  logic                     address_valid_strobe_n;
  logic                     block_next_request_n;

  assign address_n = cpu_oe ? cpu_addr_n_o : (hub_strap_oe ? hub_strap_n_o : '1);
  assign request_n = cpu_oe ? cpu_req_n_o : '1;
  assign address_source_strobes_n = cpu_oe ? cpu_strobe_n_o : 2'h3;
  assign address_valid_strobe_n = cpu_oe ? cpu_avs_n_o : 1'b1;
  assign block_next_request_n = (cpu_bnr_oe ? cpu_bnr_n_o : 1'b1) & (hub_bnr_oe ? hub_bnr_n_o : 1'b1);

  modport cpu (
    input  bclk, priority_agent_request_n, addr_bit20_mask_n, target_ready_n, rst_pin,
    input  address_n, block_next_request_n,
    output cpu_addr_n_o, cpu_req_n_o, cpu_strobe_n_o, cpu_avs_n_o, cpu_oe,
    output cpu_bnr_n_o, cpu_bnr_oe, symmetric_bus_request_n, breakpoint_monitor_pins_n
  );
  modport hub (
    output bclk, priority_agent_request_n, addr_bit20_mask_n, target_ready_n, rst_pin,
    output hub_bnr_n_o, hub_bnr_oe, hub_strap_n_o, hub_strap_oe,
    input  address_n, request_n, address_source_strobes_n, address_valid_strobe_n,
    input  block_next_request_n, symmetric_bus_request_n, breakpoint_monitor_pins_n
  );
endinterface

/* File: hdl/hba_cpu_end.sv */
/*
  Processor end: issues two-subphase address phases on the host bus,
  arbitrates as symmetric agent, honours stall, and priority request unless locked,
  masks address bit 20, captures straps and drives breakpoint pins.
  Assumes the hub end drives the bus clock and the reset pin.
*/
`timescale 1ns/1ps
`include "hba_regs.svh"
module hba_cpu_end (
  // Core clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Bus side
  hba_bus_if.cpu                       bus,
  // User request
  input  wire logic                    req_valid,
  output      logic                    req_ready,
  input  wire logic [`HBA_ADDR_W-1:0]  req_addr,
  input  wire logic [`HBA_REQ_W-1:0]   req_type,
  input  wire logic                    req_locked,
  // User status
  input  wire logic                    stall_request,
  input  wire logic [`HBA_BPM_W-1:0]   monitor_status,
  output      logic [`HBA_ADDR_W-1:0]  strap_value,
  output      logic                    mask_active
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] bclk_s, prio_s, mask_s, rstp_s;
  logic       bclk_d;
  logic [`HBA_ADDR_W-1:0] addr_s1, addr_s2;
  always_ff @(posedge clk) begin
    bclk_s  <= {bclk_s[0], bus.bclk};
    prio_s  <= {prio_s[0], bus.priority_agent_request_n};
    mask_s  <= {mask_s[0], bus.addr_bit20_mask_n};
    rstp_s  <= {rstp_s[0], bus.rst_pin};
    addr_s1 <= bus.address_n;
    addr_s2 <= addr_s1;
    bclk_d  <= bclk_s[1];
  end
  logic bnr_s1, bnr_s2;
  always_ff @(posedge clk) begin
    bnr_s1 <= bus.block_next_request_n;
    bnr_s2 <= bnr_s1;
  end

  logic bclk_rise;
  assign bclk_rise = bclk_s[1] & ~bclk_d;

  ////////////////////////////////////////////////////////////////////////
  // strap capture in reset
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_value <= '0;
    end else if (rstp_s[1]) begin
      strap_value <= ~addr_s2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_active <= 1'b0;
    end else begin
      mask_active <= ~mask_s[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  hba_pkg::hba_state_t state;
  hba_pkg::hba_addr_t  addr_q;
  hba_pkg::hba_req_t   type_q;
  logic                locked_q;
  logic                stalled, prio_seen;
  assign stalled   = ~bnr_s2;
  assign prio_seen = ~prio_s[1];
  // Ready only when idle and out of bus reset
  assign req_ready = (state == hba_pkg::HBA_IDLE) & ~rstp_s[1];

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= hba_pkg::HBA_IDLE;
      addr_q   <= '0;
      type_q   <= '0;
      locked_q <= 1'b0;
    end else begin
      case (state)
        hba_pkg::HBA_IDLE: begin
          if (req_valid & req_ready) begin
            addr_q   <= req_addr & ~({{(`HBA_ADDR_W-1){1'b0}}, mask_active} << (`HBA_MASK_BIT - `HBA_ADDR_LO));
            type_q   <= req_type;
            locked_q <= req_locked;
            state    <= hba_pkg::HBA_ARB;
          end
        end
        hba_pkg::HBA_ARB: begin
          if (bclk_rise & ~stalled & (~prio_seen | locked_q)) begin
            state <= hba_pkg::HBA_SUB1;
          end
        end
        hba_pkg::HBA_SUB1: begin
          if (bclk_rise) begin
            state <= hba_pkg::HBA_SUB2;
          end
        end
        hba_pkg::HBA_SUB2: begin
          if (bclk_rise) begin
            state <= hba_pkg::HBA_DONE;
          end
        end
        hba_pkg::HBA_DONE: begin
          state <= hba_pkg::HBA_IDLE;
        end
        default: begin
          state <= hba_pkg::HBA_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive, active low except the enables cpu_oe and cpu_bnr_oe
  // low means asserted
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.symmetric_bus_request_n <= 1'b1;
    end else begin
      bus.symmetric_bus_request_n <= ~(state == hba_pkg::HBA_ARB || state == hba_pkg::HBA_SUB1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.cpu_oe         <= 1'b0;
      bus.cpu_avs_n_o    <= 1'b1;
      bus.cpu_addr_n_o   <= '1;
      bus.cpu_req_n_o    <= '1;
      bus.cpu_strobe_n_o <= 2'h3;
    end else begin
      bus.cpu_oe <= (state == hba_pkg::HBA_SUB1) | (state == hba_pkg::HBA_SUB2);
      bus.cpu_avs_n_o <= ~(state == hba_pkg::HBA_SUB1);
      if (state == hba_pkg::HBA_SUB1) begin
        bus.cpu_addr_n_o <= ~addr_q;
        bus.cpu_req_n_o  <= ~type_q;
      end else if (state == hba_pkg::HBA_SUB2) begin
        bus.cpu_addr_n_o <= ~{{(`HBA_ADDR_W-`HBA_REQ_W){1'b0}}, type_q};
        bus.cpu_req_n_o  <= ~type_q;
      end
      if (state == hba_pkg::HBA_SUB1 || state == hba_pkg::HBA_SUB2) begin
        bus.cpu_strobe_n_o <= {2{bclk_s[1]}};
      end else begin
        bus.cpu_strobe_n_o <= 2'h3;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.cpu_bnr_n_o <= 1'b1;
      bus.cpu_bnr_oe  <= 1'b0;
    end else begin
      bus.cpu_bnr_n_o <= ~stall_request;
      bus.cpu_bnr_oe  <= stall_request;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.breakpoint_monitor_pins_n <= '1;
    end else begin
      bus.breakpoint_monitor_pins_n <= ~monitor_status;
    end
  end

endmodule

/* File: hdl/hba_hub_end.sv */
/*
  Hub end: makes the bus clock and reset pin, drives straps, raises the
  priority request, stall and bit 20 mask, and captures address phases.
  Assumes the processor end issues phases as described by the interface.
*/
`timescale 1ns/1ps
`include "hba_regs.svh"
module hba_hub_end (
  // Core clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Bus side
  hba_bus_if.hub                       bus,
  // User control
  input  wire logic                    bus_reset,
  input  wire logic [`HBA_ADDR_W-1:0]  strap_drive,
  input  wire logic                    want_priority,
  input  wire logic                    stall,
  input  wire logic                    real_mode_mask,
  input  wire logic                    io_write_ready,
  // Captured phase, bus request and monitor pins
  output      logic                    phase_valid,
  output      logic [`HBA_ADDR_W-1:0]  phase_addr,
  output      logic [`HBA_REQ_W-1:0]   phase_type,
  output      logic                    cpu_wants_bus,
  output      logic [`HBA_BPM_W-1:0]   monitor_seen
);

  // Bus clock divider
  logic [3:0] div;
  always_ff @(posedge clk) begin
    if (rst) begin
      div      <= '0;
      bus.bclk <= 1'b0;
    end else if (div == 4'(`HBA_BCLK_HALF - 1)) begin
      div      <= '0;
      bus.bclk <= ~bus.bclk;
    end else begin
      div <= div + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.rst_pin                  <= 1'b1;
      bus.hub_strap_oe             <= 1'b0;
      bus.hub_strap_n_o            <= '1;
      bus.priority_agent_request_n <= 1'b1;
      bus.hub_bnr_n_o              <= 1'b1;
      bus.hub_bnr_oe               <= 1'b0;
      bus.addr_bit20_mask_n        <= 1'b1;
      bus.target_ready_n           <= 1'b1;
    end else begin
      bus.rst_pin                  <= bus_reset;
      bus.hub_strap_oe             <= bus_reset;
      bus.hub_strap_n_o            <= ~strap_drive;
      bus.priority_agent_request_n <= ~want_priority;
      bus.hub_bnr_n_o              <= ~stall;
      bus.hub_bnr_oe               <= stall;
      bus.addr_bit20_mask_n        <= ~real_mode_mask;
      bus.target_ready_n           <= ~io_write_ready;
    end
  end

  // Synchronise processor pins
  logic [1:0] avs_s, str_s, str1_s, sbr_s;
  logic       str_d, str1_d;
  logic [`HBA_ADDR_W-1:0] a1, a2;
  logic [`HBA_REQ_W-1:0]  r1, r2;
  logic [`HBA_BPM_W-1:0]  b1, b2;
  always_ff @(posedge clk) begin
    avs_s <= {avs_s[0], bus.address_valid_strobe_n};
    str_s <= {str_s[0], bus.address_source_strobes_n[0]};
    sbr_s <= {sbr_s[0], bus.symmetric_bus_request_n};
    str_d <= str_s[1];
    str1_s <= {str1_s[0], bus.address_source_strobes_n[1]};
    str1_d <= str1_s[1];
    a1    <= bus.address_n;
    a2    <= a1;
    r1    <= bus.request_n;
    r2    <= r1;
    b1    <= bus.breakpoint_monitor_pins_n;
    b2    <= b1;
  end

  // Capture first subphase on strobe edge while valid
  // strobe 0 low bits and type, strobe 1 high bits
  logic got_addr;
  logic lo_edge, hi_edge;
  assign lo_edge = str_s[1] ^ str_d;
  assign hi_edge = str1_s[1] ^ str1_d;
  always_ff @(posedge clk) begin
    if (rst) begin
      got_addr    <= 1'b0;
      phase_valid <= 1'b0;
      phase_addr  <= '0;
      phase_type  <= '0;
    end else begin
      phase_valid <= 1'b0;
      if (lo_edge & ~avs_s[1] & ~got_addr) begin
        phase_addr[`HBA_LOW_W-1:0] <= ~a2[`HBA_LOW_W-1:0];
        phase_type                 <= ~r2;
        got_addr                   <= 1'b1;
      end else if (got_addr & avs_s[1] & lo_edge) begin
        got_addr    <= 1'b0;
        phase_valid <= 1'b1;
      end
      if (hi_edge & ~avs_s[1] & ~got_addr) begin
        phase_addr[`HBA_ADDR_W-1:`HBA_LOW_W] <= ~a2[`HBA_ADDR_W-1:`HBA_LOW_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_wants_bus <= 1'b0;
      monitor_seen  <= '0;
    end else begin
      cpu_wants_bus <= ~sbr_s[1];
      monitor_seen  <= ~b2;
    end
  end

endmodule

/* File: hdl/hba_pkg.sv */
/*
  Types used by the processor end of the host bus address and arbitration block.
  Assumes the header hba_regs.svh is on the include path.
*/
`include "hba_regs.svh"
package hba_pkg;
  typedef enum logic [2:0] {
    HBA_IDLE  = 3'b000,
    HBA_ARB   = 3'b001,
    HBA_SUB1  = 3'b010,
    HBA_SUB2  = 3'b011,
    HBA_DONE  = 3'b100
  } hba_state_t;
  typedef logic [`HBA_ADDR_W-1:0] hba_addr_t;
  typedef logic [`HBA_REQ_W-1:0]  hba_req_t;
endpackage

/* File: hdl/hba_regs.svh */
/*
  Timing counts and field positions for the host bus address and arbitration block.
  Assumes inclusion by bare name from the design files and the interface.
*/
`ifndef HBA_REGS_SVH
`define HBA_REGS_SVH

// Address, request and monitor widths and bit positions
`define HBA_ADDR_HI      35
`define HBA_ADDR_LO      3
`define HBA_ADDR_W       33
`define HBA_REQ_W        5
`define HBA_SPLIT_BIT    17
`define HBA_MASK_BIT     20
`define HBA_LOW_W        14
`define HBA_HIGH_W       19
`define HBA_BPM_W        4
// Bus clock divider: half period in core clocks
`define HBA_BCLK_HALF    4
// Strap capture: cycles of stable reset before sampling
`define HBA_STRAP_WAIT   2

`endif

/* File: testbench/hba_assertions.sv */
/*
  Checker for the shared host bus between processor and hub ends.
  Assumes one core clock domain and pins active low on the interface, except rst_pin, which is high in bus reset.
*/
`timescale 1ns/1ps
`include "hba_regs.svh"
module hba_assertions (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // Bus wires
  input wire logic                   bclk,
  input wire logic                   cpu_oe,
  input wire logic                   rst_pin,
  input wire logic [`HBA_ADDR_W-1:0] address_n,
  input wire logic [1:0]             address_source_strobes_n,
  input wire logic                   address_valid_strobe_n,
  input wire logic                   block_next_request_n,
  input wire logic                   priority_agent_request_n,
  input wire logic                   symmetric_bus_request_n,
  input wire logic [`HBA_REQ_W-1:0]  request_n,
  // Processor request qualifier
  input wire logic                   req_locked
);
  wire avs_n = address_valid_strobe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  chk_bclk_period: assert property (
    $rose(bclk) |-> bclk[*4] ##1 !bclk[*4] ##1 bclk) else $error("bus clock period wrong");
  chk_valid_one_period: assert property (
    $fell(avs_n) |-> !avs_n[*8] ##1 avs_n) else $error("valid strobe length wrong");
  chk_two_subphases: assert property (
    $fell(avs_n) |-> cpu_oe[*8] ##1 cpu_oe[*8] ##[1:2] !cpu_oe) else $error("phase length wrong");
  chk_addr_holds: assert property (
    $fell(avs_n) |=> $stable(address_n)[*7]) else $error("address moved in subphase");
  chk_strobe_toggles: assert property (
    $fell(avs_n) |-> ##[2:9] $changed(address_source_strobes_n)) else $error("strobes idle");
  chk_request_first: assert property (
    $fell(avs_n) |-> !$past(symmetric_bus_request_n)) else $error("phase without bus request");
  chk_stall_blocks: assert property (
    !block_next_request_n[*6] |=> !$fell(avs_n)) else $error("phase during stall");
  chk_priority_yield: assert property (
    (!priority_agent_request_n && !req_locked)[*6] |=> !$fell(avs_n)) else $error("phase during priority");
  chk_sub2_type: assert property (
    $fell(avs_n) |-> ##8 (address_n == {{(`HBA_ADDR_W-`HBA_REQ_W){1'b1}}, request_n}))
    else $error("type missing in subphase two");
  chk_strap_quiet: assert property (
    rst_pin |-> !cpu_oe) else $error("address driven in bus reset");
  ////////////////////////////////////////////////////////////////
  cover property ($fell(avs_n));
  cover property (!block_next_request_n[*6]);
  cover property (!priority_agent_request_n[*6]);
  cover property (!priority_agent_request_n && req_locked && $fell(avs_n));
endmodule

/* File: testbench/host_bus_address_and_arbitration_tb.sv */
/*
  Testbench joining processor and hub ends through the bus interface.
  Assumes both ends share one core clock and reset.
*/
`timescale 1ns/1ps
`include "hba_regs.svh"
`define CHK(a,b,m) begin compares++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: %s", $time, m); end end
module host_bus_address_and_arbitration_tb;
  logic                   clk = 1'b0;
  logic                   rst, req_valid, req_ready, stall_request, mask_active, req_locked;
  logic                   bus_reset, want_priority, stall, real_mode_mask, io_write_ready;
  logic                   phase_valid, cpu_wants_bus;
  logic [`HBA_ADDR_W-1:0] req_addr, strap_value, strap_drive, phase_addr;
  logic [`HBA_REQ_W-1:0]  req_type, phase_type;
  logic [`HBA_BPM_W-1:0]  monitor_status, monitor_seen;
  logic [31:0]            seed = 32'h11;
  int                     error_cnt, compares, n;
  hba_bus_if bus ();
  ////////////////////////////////////////////////////////////////
  hba_cpu_end i_hba_cpu_end (.clk(clk), .rst(rst), .bus(bus), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_type(req_type), .req_locked(req_locked),
    .stall_request(stall_request), .monitor_status(monitor_status),
    .strap_value(strap_value), .mask_active(mask_active));
  hba_hub_end i_hba_hub_end (.clk(clk), .rst(rst), .bus(bus), .bus_reset(bus_reset),
    .strap_drive(strap_drive), .want_priority(want_priority), .stall(stall),
    .real_mode_mask(real_mode_mask), .io_write_ready(io_write_ready),
    .phase_valid(phase_valid), .phase_addr(phase_addr), .phase_type(phase_type),
    .cpu_wants_bus(cpu_wants_bus), .monitor_seen(monitor_seen));
  hba_assertions chk (.clk(clk), .rst(rst), .bclk(bus.bclk), .cpu_oe(bus.cpu_oe),
    .rst_pin(bus.rst_pin), .address_n(bus.address_n),
    .address_source_strobes_n(bus.address_source_strobes_n),
    .address_valid_strobe_n(bus.address_valid_strobe_n),
    .block_next_request_n(bus.block_next_request_n),
    .priority_agent_request_n(bus.priority_agent_request_n),
    .symmetric_bus_request_n(bus.symmetric_bus_request_n),
    .request_n(bus.request_n), .req_locked(req_locked));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [`HBA_ADDR_W-1:0] exp_addr(input logic [`HBA_ADDR_W-1:0] a, input logic m);
    exp_addr = a;
    if (m) exp_addr[`HBA_MASK_BIT-`HBA_ADDR_LO] = 1'b0;
  endfunction
  task automatic results();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // One transfer; blk 1 hub stall, 2 processor stall, 3 priority, 4 locked under priority
  task automatic txn(input int blk);
    logic [63:0]            r;
    logic [`HBA_ADDR_W-1:0] a;
    logic [`HBA_REQ_W-1:0]  t;
    int                     seen;
    r = {xs(), xs()};
    a = r[`HBA_ADDR_W-1:0];
    t = r[63:59];
    if (real_mode_mask) a[`HBA_MASK_BIT-`HBA_ADDR_LO] = 1'b1;
    monitor_status = r[58:55];
    stall = (blk == 1);
    stall_request = (blk == 2);
    want_priority = (blk == 3) || (blk == 4);
    req_locked = (blk == 4);
    // Blockers reach the far synchronisers before the request
    repeat (6) @(posedge clk);
    #1 req_addr = a;
    req_type = t;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 200) begin
      `CHK(1'b0, 1'b1, "request never taken")
      results();
    end
    @(posedge clk);
    #1 req_valid = 1'b0;
    seen = 0;
    if (blk != 0 && blk != 4) begin
      repeat (40) begin
        @(negedge clk);
        if (phase_valid === 1'b1) seen++;
      end
      `CHK(seen, 0, "phase while blocked")
      `CHK(cpu_wants_bus, 1'b1, "no bus request")
      @(posedge clk);
      #1 {stall, stall_request, want_priority} = 3'h0;
    end
    n = 0;
    while (phase_valid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        `CHK(1'b0, 1'b1, "timeout")
        results();
      end
    end
    `CHK(phase_addr, exp_addr(a, real_mode_mask), "phase address")
    `CHK(phase_type, t, "phase type")
    `CHK(monitor_seen, monitor_status, "monitor pins")
    if (blk == 4) begin
      @(posedge clk);
      #1 {want_priority, req_locked} = 2'h0;
    end
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst, bus_reset, req_valid, stall_request, want_priority, stall} = 6'h30;
    {real_mode_mask, io_write_ready, req_locked, req_addr, req_type, monitor_status} = '0;
    strap_drive = {1'b1, xs()};
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge clk);
    #1 bus_reset = 1'b0;
    repeat (10) @(posedge clk);
    #1 `CHK(strap_value, strap_drive, "strap capture")
    for (int i = 0; i < 4; i++) txn(i);
    // mask only in real mode, valid with target ready
    real_mode_mask = 1'b1;
    io_write_ready = 1'b1;
    repeat (20) @(posedge clk);
    #1 `CHK(mask_active, 1'b1, "mask level")
    for (int i = 0; i < 8; i++) txn(0);
    real_mode_mask = 1'b0;
    repeat (20) @(posedge clk);
    #1 `CHK(mask_active, 1'b0, "mask release")
    for (int i = 0; i < 10; i++) txn(i % 5);
    results();
  end
endmodule
